/* File: rtl/eba_add8.sv */
// Eight-bit adder and subtractor with carry, half-carry and overflow.
`timescale 1ns/1ps
module eba_add8 (
    // Operands.
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       ci,
    input  wire logic       sub,
    // Result.
    output logic [7:0]      sum,
    output logic            co,
    output logic            hc,
    output logic            ov
);
    logic [8:0] full;
    logic [4:0] half;

    // A set carry out means a borrow when subtracting.
    always_comb begin
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, ci};
            half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        end
        sum = full[7:0];
        co  = full[8];
        hc  = half[4];
        if (sub) begin
            ov = (a[7] & ~b[7] & ~sum[7]) | (~a[7] & b[7] & sum[7]);
        end else begin
            ov = (a[7] & b[7] & ~sum[7]) | (~a[7] & ~b[7] & sum[7]);
        end
    end
endmodule

/* File: rtl/eba_alu.sv */
// Eight-bit arithmetic, logic, jump and low I/O bit datapath.
//
// What this block does
// - Register add, with carry, one cycle, flags
// - Word immediate add, two cycles, ZCNVS flags
// - Register subtract, with borrow, one cycle
// - Constant subtract, with borrow, one cycle
// - Word immediate subtract, two cycles, ZCNVS
// - Conjunction with register or constant, ZNV
// - Inclusive and exclusive or, ZNV, one cycle
// - Set masked bits, ZNV, one cycle
// - Clear masked bits via inverted mask
// - Test register against itself, value kept
// - Pointer jump loads counter, two cycles
// - Bit set and clear only addresses 0x00-0x1F
// - Bit skips test one low I/O bit
// - Bit set and clear touch one bit
// - Some flags clear on writing one
`timescale 1ns/1ps
module eba_alu import eba_pkg::*; (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         srst,
    // Instruction request from the decoder.
    input  wire logic         req_valid,
    output logic              req_ready,
    input  wire eba_req_s     req,
    // Result to the register file and program counter.
    output eba_res_s          res,
    output logic [7:0]        flags,
    // Register port.
    input  wire logic [7:0]   bus_addr,
    input  wire logic [7:0]   bus_wdata,
    input  wire logic         bus_wr,
    input  wire logic         bus_rd,
    output logic [7:0]        bus_rdata,
    // Low I/O space.
    input  wire logic [255:0] io_flag_set,
    output logic [255:0]      io_regs
);
    eba_state_e st_q;
    eba_state_e st_d;
    logic [1:0] cnt_q;
    eba_req_s   req_q;
    logic [7:0] lo_q;
    logic       lc_q;
    logic [7:0] sreg_q;
    logic [7:0] sreg_d;
    eba_res_s   res_q;
    eba_res_s   res_d;
    logic       accept;
    logic       finish;

    logic [7:0] add_a;
    logic [7:0] add_b;
    logic       add_ci;
    logic       add_sub;
    logic [7:0] add_sum;
    logic       add_co;
    logic       add_hc;
    logic       add_ov;

    logic [7:0] io_q [IO_REGS];
    logic       io_bit_we;
    logic       io_bit_val;
    logic       io_in_range;
    logic       io_sel_bit;
    logic [7:0] logic_r;

    assign req_ready = (st_q == ST_IDLE);
    assign accept    = req_valid & req_ready;
    assign finish    = (st_q == ST_LONG) && (cnt_q == LONG_OP_CYCLES);
    assign res       = res_q;
    assign flags     = sreg_q;

    eba_add8 u_add (
        .a   (add_a),
        .b   (add_b),
        .ci  (add_ci),
        .sub (add_sub),
        .sum (add_sum),
        .co  (add_co),
        .hc  (add_hc),
        .ov  (add_ov)
    );

    // Operand selection for the shared adder.
    always_comb begin
        add_a   = req.rd_val;
        add_b   = req.rr_val;
        add_ci  = 1'b0;
        add_sub = 1'b0;
        if (st_q == ST_LONG) begin
            add_a   = req_q.pair[15:8];
            add_b   = 8'h00;
            add_ci  = lc_q;
            add_sub = (req_q.op == OP_WDIFF);
        end else begin
            unique case (req.op)
                OP_SUMC: begin
                    add_ci = sreg_q[FLG_C];
                end
                OP_DIFF: begin
                    add_sub = 1'b1;
                end
                OP_DIFFB: begin
                    add_sub = 1'b1;
                    add_ci  = sreg_q[FLG_C];
                end
                OP_KDIFF: begin
                    add_b   = req.k;
                    add_sub = 1'b1;
                end
                OP_KDIFFB: begin
                    add_b   = req.k;
                    add_sub = 1'b1;
                    add_ci  = sreg_q[FLG_C];
                end
                OP_WSUM, OP_WDIFF: begin
                    add_a   = req.pair[7:0];
                    add_b   = req.k;
                    add_sub = (req.op == OP_WDIFF);
                end
                OP_TWOS: begin
                    add_a   = 8'h00;
                    add_b   = req.rd_val;
                    add_sub = 1'b1;
                end
                OP_INC, OP_DEC: begin
                    add_b   = ONE_8;
                    add_sub = (req.op == OP_DEC);
                end
                default: begin
                    add_sub = 1'b0;
                end
            endcase
        end
    end

    // Bitwise results.
    always_comb begin
        unique case (req.op)
            OP_AND:  logic_r = req.rd_val & req.rr_val;
            OP_KAND: logic_r = req.rd_val & req.k;
            OP_OR:   logic_r = req.rd_val | req.rr_val;
            OP_KOR:  logic_r = req.rd_val | req.k;
            OP_XOR:  logic_r = req.rd_val ^ req.rr_val;
            OP_SETM: logic_r = req.rd_val | req.k;
            OP_CLRM: logic_r = req.rd_val & (ALL_ONES - req.k);
            OP_TEST: logic_r = req.rd_val & req.rd_val;
            OP_CLR:  logic_r = req.rd_val ^ req.rd_val;
            default: logic_r = 8'h00;
        endcase
    end

    // Low I/O bit access.
    assign io_in_range = ({2'b00, req.io_addr} <= IO_LAST_ADDR);
    assign io_bit_we   = accept && io_in_range &&
                         (req.op == OP_IOSET || req.op == OP_IOCLR);
    assign io_bit_val  = (req.op == OP_IOSET);
    assign io_sel_bit  = io_q[req.io_addr[4:0]][req.io_bit];

    // Result and flag computation for the cycle that finishes an op.
    always_comb begin
        res_d  = '0;
        sreg_d = sreg_q;
        if (finish) begin
            res_d.done = 1'b1;
            unique case (req_q.op)
                OP_WSUM, OP_WDIFF: begin
                    res_d.pair_we       = 1'b1;
                    res_d.pair_val      = {add_sum, lo_q};
                    sreg_d[FLG_Z]       = ({add_sum, lo_q} == 16'h0000);
                    sreg_d[FLG_C]       = add_co;
                    sreg_d[FLG_N]       = add_sum[7];
                    sreg_d[FLG_V]       = add_ov;
                    sreg_d[FLG_S]       = add_sum[7] ^ add_ov;
                end
                OP_RELATIVE_JUMP: begin
                    res_d.pc_we  = 1'b1;
                    res_d.pc_val = req_q.pc + {{4{req_q.joff[11]}},
                                   req_q.joff} + 16'h0001;
                end
                OP_PJMP: begin
                    res_d.pc_we  = 1'b1;
                    res_d.pc_val = req_q.ptr;
                end
                default: begin
                    res_d.done = 1'b1;
                end
            endcase
        end else if (accept && st_d == ST_IDLE) begin
            res_d.done = 1'b1;
            unique case (req.op)
                OP_SUM, OP_SUMC, OP_DIFF, OP_DIFFB,
                OP_KDIFF, OP_KDIFFB: begin
                    res_d.rd_we   = 1'b1;
                    res_d.rd_val  = add_sum;
                    sreg_d[FLG_Z] = (add_sum == 8'h00);
                    sreg_d[FLG_C] = add_co;
                    sreg_d[FLG_N] = add_sum[7];
                    sreg_d[FLG_V] = add_ov;
                    sreg_d[FLG_H] = add_hc;
                end
                OP_TWOS: begin
                    res_d.rd_we   = 1'b1;
                    res_d.rd_val  = add_sum;
                    sreg_d[FLG_Z] = (add_sum == 8'h00);
                    sreg_d[FLG_C] = add_co;
                    sreg_d[FLG_N] = add_sum[7];
                    sreg_d[FLG_V] = add_ov;
                    sreg_d[FLG_H] = add_hc;
                end
                OP_ONES: begin
                    res_d.rd_we   = 1'b1;
                    res_d.rd_val  = ALL_ONES - req.rd_val;
                    sreg_d[FLG_Z] = (req.rd_val == ALL_ONES);
                    sreg_d[FLG_C] = 1'b1;
                    sreg_d[FLG_N] = ~req.rd_val[7];
                    sreg_d[FLG_V] = 1'b0;
                end
                OP_INC, OP_DEC: begin
                    res_d.rd_we   = 1'b1;
                    res_d.rd_val  = add_sum;
                    sreg_d[FLG_Z] = (add_sum == 8'h00);
                    sreg_d[FLG_N] = add_sum[7];
                    sreg_d[FLG_V] = add_ov;
                end
                OP_AND, OP_KAND, OP_OR, OP_KOR, OP_XOR,
                OP_SETM, OP_CLRM, OP_CLR: begin
                    res_d.rd_we   = 1'b1;
                    res_d.rd_val  = logic_r;
                    sreg_d[FLG_Z] = (logic_r == 8'h00);
                    sreg_d[FLG_N] = logic_r[7];
                    sreg_d[FLG_V] = 1'b0;
                end
                OP_TEST: begin
                    sreg_d[FLG_Z] = (logic_r == 8'h00);
                    sreg_d[FLG_N] = logic_r[7];
                    sreg_d[FLG_V] = 1'b0;
                end
                OP_SET: begin
                    res_d.rd_we  = 1'b1;
                    res_d.rd_val = ALL_ONES;
                end
                OP_IOSKZ: begin
                    res_d.skip = io_in_range && !io_sel_bit;
                end
                OP_IOSKO: begin
                    res_d.skip = io_in_range && io_sel_bit;
                end
                default: begin
                    res_d.done = 1'b1;
                end
            endcase
        end
    end

    // Sequencing of two-cycle operations.
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (accept && (req.op == OP_WSUM || req.op == OP_WDIFF ||
                    req.op == OP_RELATIVE_JUMP || req.op == OP_PJMP)) begin
                    st_d = ST_LONG;
                end
            end
            ST_LONG: begin
                if (finish) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q  <= ST_IDLE;
            cnt_q <= SHORT_OP_CYCLES;
        end else begin
            st_q <= st_d;
            if (accept) begin
                cnt_q <= SHORT_OP_CYCLES + 2'h1;
            end else if (st_q == ST_LONG) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    // Latched request and low byte of a word operation.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            req_q <= '0;
            lo_q  <= 8'h00;
            lc_q  <= 1'b0;
        end else if (accept) begin
            req_q <= req;
            lo_q  <= add_sum;
            lc_q  <= add_co;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    // Flags: an instruction update that changes them wins over a port write.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sreg_q <= FLAG_RESET;
        end else if (sreg_d != sreg_q) begin
            sreg_q <= sreg_d;
        end else if (bus_wr && bus_addr == FLAG_ADDR) begin
            sreg_q <= bus_wdata;
        end
    end

    // Low I/O register bank.
    for (genvar i = 0; i < IO_REGS; i++) begin : g_io
        eba_io_reg #(
            .W1C (IO_W1C_MAP[i*8 +: 8])
        ) u_io (
            .sys_clk   (sys_clk),
            .srst      (srst),
            .bus_we    (bus_wr && bus_addr == 8'(i)),
            .bus_wdata (bus_wdata),
            .bit_we    (io_bit_we && req.io_addr[4:0] == 5'(i)),
            .bit_idx   (req.io_bit),
            .bit_val   (io_bit_val),
            .hw_set    (io_flag_set[i*8 +: 8]),
            .q         (io_q[i])
        );
        assign io_regs[i*8 +: 8] = io_q[i];
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            if (bus_addr <= IO_LAST_ADDR) begin
                bus_rdata <= io_q[bus_addr[4:0]];
            end else if (bus_addr == FLAG_ADDR) begin
                bus_rdata <= sreg_q;
            end else if (bus_addr == STATE_ADDR) begin
                bus_rdata <= {7'h00, st_q == ST_LONG};
            end else begin
                bus_rdata <= 8'h00;
            end
        end else begin
            bus_rdata <= 8'h00;
        end
    end
endmodule

/* File: rtl/eba_io_reg.sv */
// One low I/O register with bit access and write-one-to-clear flags.
`timescale 1ns/1ps
module eba_io_reg import eba_pkg::*; #(
    parameter logic [7:0] W1C = 8'h00
) (
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       srst,
    // Register port write.
    input  wire logic       bus_we,
    input  wire logic [7:0] bus_wdata,
    // Single-bit write.
    input  wire logic       bit_we,
    input  wire logic [2:0] bit_idx,
    input  wire logic       bit_val,
    // Flag events and value.
    input  wire logic [7:0] hw_set,
    output logic [7:0]      q
);
    logic [7:0] d;

    always_comb begin
        d = q;
        if (bus_we) begin
            d = (bus_wdata & ~W1C) | (q & W1C & ~bus_wdata);
        end
        // Only the addressed bit is touched.
        if (bit_we) begin
            if (W1C[bit_idx]) begin
                if (bit_val) begin
                    d[bit_idx] = 1'b0;
                end
            end else begin
                d[bit_idx] = bit_val;
            end
        end
        // A flag event wins over a clear in the same cycle.
        d = d | (hw_set & W1C);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= IO_RESET;
        end else begin
            q <= d;
        end
    end
endmodule

/* File: shared/eba_pkg.sv */
// Shared types and constants of the eight-bit arithmetic and jump datapath.
package eba_pkg;

    // Status flag positions in the flag register.
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;

    // Register port map.
    localparam logic [7:0] IO_LAST_ADDR = 8'h1f;
    localparam logic [7:0] FLAG_ADDR    = 8'h20;
    localparam logic [7:0] STATE_ADDR   = 8'h21;
    localparam int         STATE_BUSY   = 0;

    // Low I/O space.
    localparam int         IO_REGS      = 32;
    localparam logic [5:0] IO_BIT_LIMIT = 6'h1f;

    // Bits that clear when a one is written to them, per I/O register.
    localparam logic [255:0] IO_W1C_MAP =
        (256'he0 << (8'h0e * 8)) |
        (256'h10 << (8'h08 * 8)) |
        (256'h10 << (8'h06 * 8));

    // Values after reset.
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] IO_RESET   = 8'h00;

    // Constant operands.
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ONE_8    = 8'h01;

    // Cycle counts.
    localparam logic [1:0] SHORT_OP_CYCLES = 2'h1;
    localparam logic [1:0] LONG_OP_CYCLES  = 2'h2;

    typedef enum logic [4:0] {
        OP_NONE, OP_SUM, OP_SUMC, OP_DIFF, OP_DIFFB, OP_KDIFF, OP_KDIFFB,
        OP_WSUM, OP_WDIFF, OP_AND, OP_KAND, OP_OR, OP_KOR, OP_XOR,
        OP_SETM, OP_CLRM, OP_TEST, OP_ONES, OP_TWOS, OP_INC, OP_DEC,
        OP_CLR, OP_SET, OP_RELATIVE_JUMP, OP_PJMP, OP_IOSET, OP_IOCLR,
        OP_IOSKZ, OP_IOSKO
    } eba_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LONG = 2'b10
    } eba_state_e;

    typedef struct packed {
        eba_op_e     op;
        logic [7:0]  rd_val;
        logic [7:0]  rr_val;
        logic [7:0]  k;
        logic [15:0] pair;
        logic [15:0] pc;
        logic [15:0] ptr;
        logic [11:0] joff;
        logic [5:0]  io_addr;
        logic [2:0]  io_bit;
    } eba_req_s;

    typedef struct packed {
        logic        done;
        logic        rd_we;
        logic [7:0]  rd_val;
        logic        pair_we;
        logic [15:0] pair_val;
        logic        pc_we;
        logic [15:0] pc_val;
        logic        skip;
    } eba_res_s;

endpackage

/* File: tb/eba_alu_sva.sv */
// Checker on the ports of the arithmetic and jump datapath.
`timescale 1ns/1ps
module eba_alu_sva import eba_pkg::*; (
    // Clock and reset.
    input wire logic         sys_clk,
    input wire logic         srst,
    // Request and result.
    input wire logic         req_valid,
    input wire logic         req_ready,
    input wire eba_req_s     req,
    input wire eba_res_s     res,
    input wire logic [7:0]   flags,
    // Low I/O space.
    input wire logic         bus_wr,
    input wire logic [255:0] io_flag_set,
    input wire logic [255:0] io_regs
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic        tk;
    logic [15:0] jt_q;
    assign tk = req_valid && req_ready;
    always_ff @(posedge sys_clk) begin
        jt_q <= req.pc + {{4{req.joff[11]}}, req.joff} + 16'h0001;
    end
    property p_sum;
        tk && req.op == OP_SUM |=> res.done && res.rd_we &&
            res.rd_val == $past(req.rd_val) + $past(req.rr_val);
    endproperty
    a_sum: assert property (p_sum) else $error("bad sum");
    property p_wsum;
        tk && req.op == OP_WSUM |=> !req_ready && !res.done ##1 res.pair_we
            && res.pair_val == $past(req.pair, 2) + {8'h00, $past(req.k, 2)};
    endproperty
    a_wsum: assert property (p_wsum) else $error("bad word sum");
    property p_kand;
        tk && req.op == OP_KAND |=> res.rd_val ==
            ($past(req.rd_val) & $past(req.k)) && $stable(flags[FLG_C]);
    endproperty
    a_kand: assert property (p_kand) else $error("bad and");
    property p_clrm;
        tk && req.op == OP_CLRM |=>
            res.rd_val == ($past(req.rd_val) & ~$past(req.k));
    endproperty
    a_clrm: assert property (p_clrm) else $error("bad mask clear");
    property p_test;
        tk && req.op == OP_TEST |=> res.done && !res.rd_we &&
            flags[FLG_Z] == ($past(req.rd_val) == 8'h00);
    endproperty
    a_test: assert property (p_test) else $error("bad test");
    property p_pjmp;
        tk && req.op == OP_PJMP |=> !res.done ##1 res.pc_we &&
            res.pc_val == $past(req.ptr, 2) && $stable(flags);
    endproperty
    a_pjmp: assert property (p_pjmp) else $error("bad ptr jump");
    property p_relative_jump;
        tk && req.op == OP_RELATIVE_JUMP |=> !res.done ##1 res.pc_we &&
            res.pc_val == $past(jt_q);
    endproperty
    a_relative_jump: assert property (p_relative_jump) else $error("bad rel jump");
    property p_iohi;
        tk && req.op == OP_IOSET && req.io_addr[5] && !bus_wr &&
            io_flag_set == '0 |=> $stable(io_regs);
    endproperty
    a_iohi: assert property (p_iohi) else $error("high io set");
endmodule

bind eba_alu eba_alu_sva eba_alu_sva_inst (
    .sys_clk, .srst, .req_valid, .req_ready, .req, .res, .flags,
    .bus_wr, .io_flag_set, .io_regs
);

/* File: tb/eba_alu_tb.sv */
// Self-checking bench for the arithmetic and jump datapath.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
    err_total++; $display("wrong value %s exp %h got %h", n, e, s); end end
module eba_alu_tb import eba_pkg::*; ;
    logic         sys_clk, srst, req_valid, req_ready, rdy_seen;
    logic         bus_wr, bus_rd;
    eba_req_s     req;
    eba_res_s     res;
    logic [7:0]   flags, bus_addr, bus_wdata, bus_rdata, d;
    logic [255:0] io_flag_set, io_regs, io_snap;
    logic [15:0]  pc_q, pair_q;
    int           err_total, compares, cyc;
    eba_op_e      ops [21] = '{OP_SUM, OP_SUM, OP_SUMC, OP_DIFF, OP_DIFFB,
        OP_KDIFF, OP_KDIFFB, OP_AND, OP_KAND, OP_OR, OP_KOR, OP_XOR,
        OP_SETM, OP_CLRM, OP_TEST, OP_ONES, OP_INC, OP_DEC, OP_TWOS,
        OP_CLR, OP_SET};
    logic [31:0]  tbl [21] = '{32'h0f011020, 32'h8080000b, 32'h01010300,
        32'h0001ff25, 32'h05020200, 32'h0001ff25, 32'h100f0022,
        32'hf03c3020, 32'h0ff00022, 32'h80018124, 32'h00000022,
        32'hff0ff024, 32'h01808124, 32'h0f0f0022, 32'h80000024,
        32'h0f00f025, 32'h7f00802d, 32'h01000023, 32'h00000002,
        32'h5a000002, 32'h0000ff02};

    eba_alu eba_alu_inst (.sys_clk, .srst, .req_valid, .req_ready, .req,
        .res, .flags, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
        .io_flag_set, .io_regs);
    eba_core_model eba_core_model_inst (.sys_clk, .srst, .res, .pc_q,
        .pair_q);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic run(input eba_op_e op, input logic [15:0] a,
                       input logic [7:0] b);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{op, a[7:0], b, b, a, a, a, {{4{b[7]}}, b}, a[5:0], b[2:0]};
        @(posedge sys_clk);
        req_valid <= 1'b0;
        #1;
        rdy_seen = req_ready;
        cyc = 0;
        while (res.done !== 1'b1 && cyc < 4) begin
            @(posedge sys_clk);
            #1;
            cyc++;
        end
        if (cyc == 4) begin
            err_total++;
            end_sim();
        end
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= v;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        v = bus_rdata;
    endtask

    task automatic chk_io(input logic [7:0] e);
        @(posedge sys_clk);
        #1;
        `CHK("io_reg", e, io_regs[112 +: 8])
    endtask

    initial begin
        srst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        io_flag_set = '0;
        err_total = 0;
        compares = 0;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        for (int i = 0; i < 21; i++) begin
            run(ops[i], {8'h00, tbl[i][31:24]}, tbl[i][23:16]);
            `CHK("rd_we", ops[i] != OP_TEST, res.rd_we)
            `CHK("rd_val", tbl[i][15:8], res.rd_val)
            `CHK("flags", tbl[i][7:0], flags)
            `CHK("cycles", 0, cyc)
        end
        run(OP_WDIFF, 16'h0000, 8'h01);
        `CHK("pair", 16'hffff, res.pair_val)
        `CHK("flags", 8'h15, flags)
        `CHK("ready", 1'b0, rdy_seen)
        `CHK("cycles", 1, cyc)
        run(OP_WSUM, 16'hffff, 8'h01);
        `CHK("pair_q", 16'hffff, pair_q)
        `CHK("pair", 16'h0000, res.pair_val)
        `CHK("flags", 8'h03, flags)
        `CHK("cycles", 1, cyc)
        run(OP_RELATIVE_JUMP, 16'h0010, 8'hfe);
        @(posedge sys_clk);
        #1;
        `CHK("pc", 16'h000f, pc_q)
        `CHK("pair_q", 16'h0000, pair_q)
        run(OP_PJMP, 16'h1234, 8'h00);
        `CHK("cycles", 1, cyc)
        @(posedge sys_clk);
        #1;
        `CHK("pc", 16'h1234, pc_q)
        `CHK("flags", 8'h03, flags)
        @(posedge sys_clk);
        io_flag_set <= 256'h80 << 112;
        @(posedge sys_clk);
        io_flag_set <= '0;
        run(OP_IOSET, 16'h000e, 8'h00);
        chk_io(8'h81);
        run(OP_IOSET, 16'h000e, 8'h07);
        chk_io(8'h01);
        run(OP_IOSKO, 16'h000e, 8'h00);
        `CHK("skip", 1'b1, res.skip)
        run(OP_IOSKZ, 16'h000e, 8'h00);
        `CHK("skip", 1'b0, res.skip)
        io_snap = io_regs;
        run(OP_IOSET, 16'h002e, 8'h01);
        @(posedge sys_clk);
        #1;
        `CHK("io_all", io_snap, io_regs)
        run(OP_IOCLR, 16'h000e, 8'h00);
        chk_io(8'h00);
        bus_write(8'h0e, 8'h0c);
        run(OP_IOCLR, 16'h000e, 8'h02);
        bus_read(8'h0e, d);
        `CHK("io_port", 8'h08, d)
        bus_write(FLAG_ADDR, 8'h5a);
        bus_read(FLAG_ADDR, d);
        `CHK("flag_reg", 8'h5a, d)
        bus_read(8'h40, d);
        `CHK("unmapped", 8'h00, d)
        end_sim();
    end
endmodule

/* File: tb/eba_core_model.sv */
// Core-side model that keeps the program counter and register pair that the datapath writes back.
`timescale 1ns/1ps
module eba_core_model import eba_pkg::*; (
    // Clock and reset.
    input wire logic     sys_clk,
    input wire logic     srst,
    // Write-back from the datapath.
    input wire eba_res_s res,
    output logic [15:0]  pc_q,
    output logic [15:0]  pair_q
);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pc_q   <= 16'h0000;
            pair_q <= 16'h0000;
        end else begin
            if (res.pc_we) pc_q <= res.pc_val;
            if (res.pair_we) pair_q <= res.pair_val;
        end
    end
endmodule
